// File: src/tzc_pkg.sv
/*
  Package for the timer zero counter with prescaler: register map,
  field positions, reset values and timing constants.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package tzc_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CTL_RUN = 7;
  localparam int CTL_WIDTH = 6;
  localparam int CTL_SOURCE = 5;
  localparam int CTL_EDGE = 4;
  localparam int CTL_BYPASS = 3;
  localparam int CTL_PS_LSB = 0;
  localparam int CTL_PS_W = 3;
  localparam logic [7:0] CONTROL_RESET = 8'hff;
  // ----------------------------------------------------------------
  // interrupt bits
  // ----------------------------------------------------------------
  localparam int IRQ_OVERFLOW = 0;
  localparam logic [0:0] IRQ_MASK_RESET = 1'h0;
  // ----------------------------------------------------------------
  // timing: instruction cycle is four system clocks
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int INSN_PERIOD_NS = 32;
  localparam int INSN_DIV = INSN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRESCALER_W = 8;
endpackage

// File: src/tzc_prescaler.sv
/*
  Dedicated prescaler: counts source ticks and emits one tick every
  2^(field+1) inputs. Assumes the tick input is a one-cycle pulse.
*/
`timescale 1ns/1ns
module tzc_prescaler import tzc_pkg::*; #(
  parameter int WIDTH = PRESCALER_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic [CTL_PS_W-1:0] prescale_field,
  input wire logic tick_in,
  // output
  output logic tick_out
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic [WIDTH-1:0] limit;
  logic wrap;

  // limit = 2^(field+1)-1, 1:2 up to 1:256
  assign limit = WIDTH'((9'h002 << prescale_field) - 9'h001);
  assign wrap = tick_in && (count_ff == limit);
  assign nxt_count = clear ? '0 : wrap ? '0 : tick_in ? count_ff + 1'b1 : count_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_ff <= '0;
      tick_out <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_out <= wrap && !clear;
    end
  end
endmodule

// File: src/tzc_timer.sv
/*
  Timer zero counter top: APB register slave, instruction-cycle
  divider, external pin edge detect, prescaler, 8/16-bit counter and
  overflow interrupt. Assumes the count pin is synchronous to clk_sys.
*/
//
// Behaviour
// - counter advances only while run bit is set, otherwise holds
// - width bit set gives 8-bit counter, clear gives 16-bit
// - source bit set counts pin transitions, clear counts instruction cycles
// - edge bit set counts falling pin edges, clear counts rising
// - bypass bit set feeds counter directly, clear uses prescaler output
// - prescaler divides by two to the power of field plus one
// - prescaler is dedicated to this counter, software programmed
// - control register readable and writable, resets to all ones
// - counter value readable and writable at any time
// - overflow sets sticky flag until software clears it
// - flag sets regardless of interrupt enable
// - interrupt raised only while overflow enable is set
`timescale 1ns/1ns
module tzc_timer import tzc_pkg::*; #(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count pin
  input wire logic external_count_pin,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] control_ff;
  logic [COUNT_W-1:0] count_value_ff;
  logic overflow_flag_ff;
  logic overflow_irq_enable_ff;
  logic pin_ff;
  logic [1:0] div_ff;
  logic [31:0] nxt_prdata;
  logic nxt_pready;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire access = psel && penable && !pready;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_ctl = (paddr == ADDR_CONTROL);
  wire hit_cnt = (paddr == ADDR_COUNT);
  wire hit_sts = (paddr == ADDR_IRQ_STATUS);
  wire hit_msk = (paddr == ADDR_IRQ_MASK);
  wire mapped = hit_ctl || hit_cnt || hit_sts || hit_msk;
  wire wr_ctl = wr && hit_ctl;
  wire wr_cnt = wr && hit_cnt;
  wire wr_sts = wr && hit_sts;
  wire wr_msk = wr && hit_msk;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire run_control = control_ff[CTL_RUN];
  wire width_select = control_ff[CTL_WIDTH];
  wire source_select = control_ff[CTL_SOURCE];
  wire edge_select = control_ff[CTL_EDGE];
  wire prescaler_bypass = control_ff[CTL_BYPASS];
  wire [CTL_PS_W-1:0] prescale_field = control_ff[CTL_PS_LSB +: CTL_PS_W];

  // ----------------------------------------------------------------
  // count sources
  // ----------------------------------------------------------------
  // instruction cycle clock as a one-cycle enable
  wire instruction_cycle_clock = (div_ff == 2'(INSN_DIV - 1));
  wire pin_rise = external_count_pin && !pin_ff;
  wire pin_fall = !external_count_pin && pin_ff;
  wire pin_edge = edge_select ? pin_fall : pin_rise;
  wire src_tick = source_select ? pin_edge : instruction_cycle_clock;
  wire ps_tick;
  // prescaler chain restarts on any control or count write
  wire ps_clear = wr_ctl || wr_cnt;

  // dedicated prescaler instance
  tzc_prescaler #(
    .WIDTH(PRESCALER_W)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(ps_clear),
    .prescale_field(prescale_field),
    .tick_in(src_tick && run_control),
    .tick_out(ps_tick)
  );

  wire cnt_tick = prescaler_bypass ? src_tick : ps_tick;
  wire inc = run_control && cnt_tick;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  wire [COUNT_W-1:0] top = width_select ? COUNT_W'(8'hff) : {COUNT_W{1'b1}};
  wire low_top = (count_value_ff[7:0] == 8'hff);
  wire at_top = width_select ? low_top : (count_value_ff == top);
  wire overflow = inc && at_top && !wr_cnt;
  // 8-bit mode only carries in the low byte; upper byte is left alone
  wire [COUNT_W-1:0] inc8 = {count_value_ff[COUNT_W-1:8], 8'(count_value_ff[7:0] + 8'h01)};
  wire [COUNT_W-1:0] inc16 = count_value_ff + 1'b1;
  wire [COUNT_W-1:0] nxt_count = wr_cnt ? pwdata[COUNT_W-1:0]
                               : !inc ? count_value_ff
                               : width_select ? inc8
                               : inc16;

  // ----------------------------------------------------------------
  // interrupt flag: set wins over write-one clear
  // ----------------------------------------------------------------
  wire clr_flag = wr_sts && pwdata[IRQ_OVERFLOW];
  wire nxt_flag = overflow || (overflow_flag_ff && !clr_flag);
  wire nxt_irq = nxt_flag && (wr_msk ? pwdata[IRQ_OVERFLOW] : overflow_irq_enable_ff);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_ctl) begin
      nxt_prdata = {24'h00_0000, control_ff};
    end else if (hit_cnt) begin
      nxt_prdata = 32'(count_value_ff);
    end else if (hit_sts) begin
      nxt_prdata = {31'h0000_0000, overflow_flag_ff};
    end else if (hit_msk) begin
      nxt_prdata = {31'h0000_0000, overflow_irq_enable_ff};
    end
  end
  assign nxt_pready = access;

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      control_ff <= CONTROL_RESET;
      count_value_ff <= '0;
      overflow_flag_ff <= 1'b0;
      overflow_irq_enable_ff <= IRQ_MASK_RESET;
      irq <= 1'b0;
      pin_ff <= 1'b0;
      div_ff <= 2'h0;
    end else begin
      if (wr_ctl) begin
        control_ff <= pwdata[7:0];
      end
      if (wr_msk) begin
        overflow_irq_enable_ff <= pwdata[IRQ_OVERFLOW];
      end
      count_value_ff <= nxt_count;
      overflow_flag_ff <= nxt_flag;
      irq <= nxt_irq;
      pin_ff <= external_count_pin;
      div_ff <= div_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= nxt_pready;
      pslverr <= access && !mapped;
      if (rd) begin
        prdata <= nxt_prdata;
      end
    end
  end
endmodule

// File: testbench/tzc_timer_sva.sv
/* checker: apb answer timing, error response and irq masking.
   assumes it is bound to tzc_timer and sees its ports only. */
`timescale 1ns/1ns
module tzc_timer_chk import tzc_pkg::*; #(
  parameter int COUNT_W = 16
) (
  // clock, reset and apb
  input wire logic clk_sys, rst, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr,
  // pin and interrupt
  input wire logic external_count_pin, irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic acc = psel && penable;
  wire logic mapped = paddr inside {ADDR_CONTROL, ADDR_COUNT, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_ready_answer: assert property (acc && !pready |=> pready)
    else $error("no pready after access");
  chk_ready_cause: assert property (pready |-> $past(acc))
    else $error("pready without access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_only: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped address");
  chk_err_unmapped: assert property (pready && !pwrite && !mapped |-> pslverr && prdata == 0)
    else $error("bad unmapped read");
  chk_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved outside read");
  chk_irq_masked: assert property (pready && pwrite && paddr == ADDR_IRQ_MASK
    && !pwdata[IRQ_OVERFLOW] |=> !irq) else $error("irq while masked");
  cover property (irq);
  cover property (pready && pslverr);
  cover property (pready && !pwrite && paddr == ADDR_COUNT);
endmodule

bind tzc_timer tzc_timer_chk #(.COUNT_W(COUNT_W)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_count_pin(external_count_pin), .irq(irq));

// File: testbench/tzc_pulse_src.sv
/* pulse source on the count pin.
   assumes the pin is sampled on clk_sys; levels held three clocks. */
`timescale 1ns/1ns
module tzc_pulse_src (
  // clock
  input wire logic clk_sys,
  // count pin
  output logic pin
);
  initial pin = 1'b0;
  // slow levels so the edge detector never misses one
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_sys);
      pin <= ~pin;
    end
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// File: testbench/test_timer0_counter_prescaler.sv
/* testbench for tzc_timer: apb master, integer expectations.
   assumes tzc_pulse_src drives the count pin. */
`timescale 1ns/1ns
module test_timer0_counter_prescaler;
  import tzc_pkg::*;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, irq, pin, err;
  int mismatches = 0, comparisons = 0, cyc = 0, r, e, k;
  always #4 clk_sys = ~clk_sys;
  tzc_timer u_tzc_timer (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(pin), .irq(irq));
  tzc_pulse_src u_tzc_pulse_src (.clk_sys(clk_sys), .pin(pin));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] x, g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    check(s, x, rd);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    r = $urandom(32'ha0cc);
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    rdc("control", ADDR_CONTROL, CONTROL_RESET);
    rdc("count", ADDR_COUNT, 0);
    rdc("mask", ADDR_IRQ_MASK, 0);
    apb(1, ADDR_CONTROL, 32'h5a);
    rdc("control", ADDR_CONTROL, 32'h5a);
    apb(0, 8'h10, 0);
    check("unmapped", 32'h3, {rd == 0, err});
    $display("test registers done");
    for (e = 0; e < 2; e++) begin
      apb(1, ADDR_CONTROL, 32'ha8 | (e << 4));
      apb(1, ADDR_COUNT, 0);
      u_tzc_pulse_src.toggle(1 + 2 * e);
      rdc("edges", ADDR_COUNT, 1 + e);
    end
    for (k = 0; k < 8; k++) begin
      apb(1, ADDR_CONTROL, 32'hb0 | k);
      apb(1, ADDR_COUNT, 0);
      u_tzc_pulse_src.toggle(4 << k);
      rdc("prescaled", ADDR_COUNT, 1);
    end
    $display("test edges done");
    for (e = 0; e < 2; e++) begin
      r = 8'hfc + $urandom % 4;
      apb(1, ADDR_IRQ_STATUS, 1);
      apb(1, ADDR_CONTROL, 32'hb8 | (e << 6));
      apb(1, ADDR_COUNT, 32'hff00 | r);
      u_tzc_pulse_src.toggle(8);
      rdc("wrap", ADDR_COUNT, e ? 32'hff00 | (r + 4) & 8'hff : (32'hff00 + r + 4) & 32'hffff);
      rdc("flag", ADDR_IRQ_STATUS, 1);
      check("irq", 0, irq);
    end
    apb(1, ADDR_IRQ_MASK, 1);
    repeat (2) @(posedge clk_sys);
    check("irq", 1, irq);
    rdc("flag", ADDR_IRQ_STATUS, 1);
    apb(1, ADDR_IRQ_STATUS, 1);
    repeat (2) @(posedge clk_sys);
    check("irq", 0, irq);
    rdc("flag", ADDR_IRQ_STATUS, 0);
    apb(1, ADDR_IRQ_MASK, 0);
    $display("test overflow done");
    apb(1, ADDR_CONTROL, 32'h88);
    apb(1, ADDR_COUNT, 0);
    repeat (40) @(posedge clk_sys);
    apb(1, ADDR_CONTROL, 32'h08);
    apb(0, ADDR_COUNT, 0);
    k = rd;
    check("insn ticks", 1, k >= 9 && k <= 12);
    repeat (20) @(posedge clk_sys);
    rdc("stopped", ADDR_COUNT, k);
    $display("test internal done");
    end_sim();
  end
endmodule
